// *** verilog/rtc_counter.sv ***
// Periodic real-time counter with APB registers
`default_nettype none
module rtc_counter
	import rtc_pkg::*;
(
	input wire logic pclk, // System clock, 50 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic osc_32khz_tick, // 32 kHz enable pulse
	input wire logic low_power_osc_1khz_tick, // 1 kHz enable pulse
	input wire logic ext_osc_tick, // External crystal pulse
	output logic adc_trigger, // Converter start pulse
	output logic irq // Level interrupt
);
	logic [8:0] ctrl;
	logic [7:0] modulo;
	logic [7:0] count;
	logic [7:0] next_count;
	logic match_flag;
	logic match_mask;
	logic unit_tick;
	logic match_evt;
	logic wr;
	logic rd;
	logic mapped;
	logic run;

	assign wr = psel && penable && pwrite;
	assign rd = psel && !pwrite;
	assign pready = 1'b1;
	assign run = ctrl[CTRL_EN_BIT];

	always_comb begin
		case (paddr)
			OFS_CTRL, OFS_MOD, OFS_COUNT, OFS_STATUS, OFS_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !mapped;

	rtc_prescaler u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.run(run),
		.src(clk_src_t'(ctrl[CTRL_SRC_LSB +: 2])),
		.presc_sel(ctrl[CTRL_PRESC_LSB +: 6]),
		.osc_32khz_tick(osc_32khz_tick),
		.low_power_osc_1khz_tick(low_power_osc_1khz_tick),
		.ext_osc_tick(ext_osc_tick),
		.unit_tick(unit_tick)
	);

	// Control and modulo registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
			modulo <= MOD_RESET;
			match_mask <= 1'b0;
		end else if (wr) begin
			case (paddr)
				OFS_CTRL: ctrl <= pwdata[8:0];
				OFS_MOD: modulo <= pwdata[7:0];
				OFS_MASK: match_mask <= pwdata[STAT_MATCH_BIT];
				default: ;
			endcase
		end
	end

	// Counter wraps after reaching the modulo value
	assign next_count = (count == modulo) ? COUNT_RESET : count + 8'h01;
	assign match_evt = unit_tick && (next_count == modulo);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= COUNT_RESET;
		end else if (!run) begin
			count <= COUNT_RESET;
		end else if (unit_tick) begin
			count <= next_count;
		end
	end

	// Sticky match flag: a new event beats a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_flag <= 1'b0;
		end else if (match_evt) begin
			match_flag <= 1'b1;
		end else if (wr && paddr == OFS_STATUS && pwdata[STAT_MATCH_BIT]) begin
			match_flag <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_trigger <= 1'b0;
			irq <= 1'b0;
		end else begin
			adc_trigger <= match_evt;
			irq <= (match_flag || match_evt) && match_mask;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd && !penable) begin
			case (paddr)
				OFS_CTRL: prdata <= {23'h000000, ctrl};
				OFS_MOD: prdata <= {24'h000000, modulo};
				OFS_COUNT: prdata <= {24'h000000, count};
				OFS_STATUS: prdata <= {31'h00000000, match_flag};
				OFS_MASK: prdata <= {31'h00000000, match_mask};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	a_count_steps: assert property (@(posedge pclk) disable iff (!presetn)
		run && !unit_tick && $past(run) |=> $stable(count))
		else $error("count moved without a prescaler tick");

	a_src_select: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl[1:0] == 2'b11 && run ##1 ctrl[1:0] == 2'b11 |-> !unit_tick)
		else $error("tick with no source selected");

	a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
		unit_tick && $past(count) <= $past(modulo) && $stable(modulo) && $past(run)
		|-> count <= modulo)
		else $error("count passed the modulo value");

	a_trigger_match: assert property (@(posedge pclk) disable iff (!presetn)
		adc_trigger |-> count == $past(modulo) && $past(unit_tick))
		else $error("converter trigger without a match");

	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		match_flag && match_mask ##1 match_mask |-> irq)
		else $error("interrupt missing for unmasked flag");

	a_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
		run && count == modulo && unit_tick ##0 $stable(modulo)
		|=> count == 8'h00 || !run)
		else $error("counter did not wrap to zero");

	a_flag_sticks: assert property (@(posedge pclk) disable iff (!presetn)
		adc_trigger |-> match_flag)
		else $error("match flag not set on event");

	c_match: cover property (@(posedge pclk) disable iff (!presetn) adc_trigger);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
	c_clear: cover property (@(posedge pclk) disable iff (!presetn) $fell(match_flag));
endmodule : rtc_counter
`default_nettype wire

// *** verilog/rtc_pkg.sv ***
// Constants for the periodic real-time counter
// Function
// - 8-bit counter advanced by prescaler ticks
// - Software picks 32k, 1k or external clock
// - Units from 31.25 us to 32.768 s
// - 8-bit modulo extends period up to 256x
// - Match with modulo triggers converter start
// - Periodic interrupt period set by software
`default_nettype none
package rtc_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MOD = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_MASK = 8'h10;
	localparam int CTRL_SRC_LSB = 0;
	localparam int CTRL_PRESC_LSB = 2;
	localparam int CTRL_EN_BIT = 8;
	localparam int STAT_MATCH_BIT = 0;
	localparam logic [8:0] CTRL_RESET = 9'h000;
	localparam logic [7:0] MOD_RESET = 8'hFF;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [5:0] PRESC_LAST = 6'h3B;
	localparam logic [5:0] PRESC_POW2_LAST = 6'h0F;
	localparam logic [5:0] PRESC_LIN_BASE = 6'h09;
	localparam logic [15:0] PRESC_LIN_STEP = 16'h007D;
	typedef enum logic [1:0] {
		SRC_OSC_32K = 2'b00,
		SRC_LPO_1K = 2'b01,
		SRC_EXT = 2'b10,
		SRC_NONE = 2'b11
	} clk_src_t;
	// Divide ratio: 0..15 give 2^n (up to 32768), 16..59 give 125*(n-9), up to 6250
	function automatic logic [15:0] presc_ratio(input logic [5:0] sel);
		logic [5:0] s;
		s = (sel > PRESC_LAST) ? PRESC_LAST : sel;
		if (s <= PRESC_POW2_LAST) begin
			presc_ratio = 16'h0001 << s[3:0];
		end else begin
			presc_ratio = 16'(PRESC_LIN_STEP * 16'(s - PRESC_LIN_BASE));
		end
	endfunction : presc_ratio
endpackage : rtc_pkg
`default_nettype wire

// *** verilog/rtc_prescaler.sv ***
// Clock source select and prescaler for the real-time counter
`default_nettype none
module rtc_prescaler
	import rtc_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic run, // Counting enabled
	input wire clk_src_t src, // Selected source
	input wire logic [5:0] presc_sel, // Prescaler setting
	input wire logic osc_32khz_tick, // 32 kHz enable pulse
	input wire logic low_power_osc_1khz_tick, // 1 kHz enable pulse
	input wire logic ext_osc_tick, // External crystal pulse
	output logic unit_tick // One pulse per counting unit
);
	logic src_tick;
	logic [15:0] div_cnt;
	logic [15:0] ratio;

	always_comb begin
		case (src)
			SRC_OSC_32K: src_tick = osc_32khz_tick;
			SRC_LPO_1K: src_tick = low_power_osc_1khz_tick;
			SRC_EXT: src_tick = ext_osc_tick;
			default: src_tick = 1'b0;
		endcase
	end

	assign ratio = presc_ratio(presc_sel);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 16'h0000;
			unit_tick <= 1'b0;
		end else if (!run) begin
			div_cnt <= 16'h0000;
			unit_tick <= 1'b0;
		end else if (src_tick) begin
			if (div_cnt >= ratio - 16'h0001) begin
				div_cnt <= 16'h0000;
				unit_tick <= 1'b1;
			end else begin
				div_cnt <= div_cnt + 16'h0001;
				unit_tick <= 1'b0;
			end
		end else begin
			unit_tick <= 1'b0;
		end
	end

	a_tick_needs_src: assert property (@(posedge pclk) disable iff (!presetn)
		unit_tick |-> $past(src_tick) && $past(run))
		else $error("prescaler tick without a source tick");
endmodule : rtc_prescaler
`default_nettype wire

// *** bench/test_real_time_counter.sv ***
// Self-checking bench for the periodic real-time counter
`default_nettype none
module test_real_time_counter;
	import rtc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, adc_trigger, irq, er;
	logic [2:0] tk = 3'b000;
	int fails = 0, checks_done = 0, adc_n = 0;
	typedef struct {logic [7:0] a; logic [31:0] e;} row_t;
	row_t rows[6] = '{'{OFS_CTRL, 32'h0}, '{OFS_MOD, 32'hFF}, '{OFS_COUNT, 32'h0},
		'{OFS_STATUS, 32'h0}, '{OFS_MASK, 32'h0}, '{8'h14, 32'h0}};
	rtc_counter rtc_counter_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_32khz_tick(tk[0]),
		.low_power_osc_1khz_tick(tk[1]), .ext_osc_tick(tk[2]),
		.adc_trigger(adc_trigger), .irq(irq));
	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		if (adc_trigger === 1'b1) adc_n++;
	end
	task print_verdict;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer, held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (n >= 20) begin
			fails++;
			print_verdict();
		end
	endtask : apb
	task tick(input int s, input int k);
		repeat (k) begin
			@(posedge pclk); tk[s] <= 1'b1;
			@(posedge pclk); tk[s] <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask : tick
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].e);
			chk(32'(er), 32'(rows[i].a == 8'h14));
		end
		apb(1'b1, 8'h14, 32'hFF);
		apb(1'b1, OFS_MOD, 32'h2);
		apb(1'b1, OFS_MASK, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h100);
		tick(0, 2);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk(rd, 32'h2);
		chk(32'(adc_n), 32'h1);
		chk(32'(irq), 32'h1);
		tick(1, 2);
		tick(2, 2);
		apb(1'b1, OFS_COUNT, 32'h5);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk(rd, 32'h2);
		tick(0, 1);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h1);
		repeat (2) @(negedge pclk);
		chk(32'(irq), 32'h0);
		apb(1'b1, OFS_MASK, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h106);
		tick(2, 3);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk(rd, 32'h1);
		chk(rd & 32'hFFFFFF00, 32'h0);
		tick(2, 3);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
		chk(32'(irq), 32'h0);
		chk(32'(adc_n), 32'h2);
		// Mid-run reset with the flag set and unmasked
		apb(1'b1, OFS_MASK, 32'h1);
		repeat (2) @(negedge pclk);
		chk(32'(irq), 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk(32'(irq), 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		print_verdict();
	end
endmodule : test_real_time_counter
`default_nettype wire
